// [include/dwodt_consts.svh]
// Purpose: Constants for the write termination controller
// Assumes: Included by bare name, after the package
// Notes:   Latencies are counted in device clock cycles
`ifndef DWODT_CONSTS_SVH
`define DWODT_CONSTS_SVH

// ****************************************
// Register offsets and bus answers
// ****************************************
`define DWODT_CFG_OFFSET     8'h00
`define DWODT_CTRL_OFFSET    8'h04
`define DWODT_STAT_OFFSET    8'h08
`define DWODT_LAT_OFFSET     8'h0c
`define DWODT_RESP_OKAY      2'h0
`define DWODT_RESP_DECERR    2'h3

// ****************************************
// Fields and reset values
// ****************************************
`define DWODT_CFG_RST        7'h00
`define DWODT_CTRL_RST       7'h00
`define DWODT_STAT_FAULT_BIT 16
`define DWODT_STAT_OHM_LSB   8

// ****************************************
// Latencies, set A then set B, by band
// ****************************************
`define DWODT_ONA_3          6'h04
`define DWODT_ONA_4          6'h04
`define DWODT_ONA_5          6'h06
`define DWODT_ONA_6          6'h06
`define DWODT_ONA_7          6'h08
`define DWODT_ONB_2          6'h06
`define DWODT_ONB_3          6'h0c
`define DWODT_ONB_4          6'h0e
`define DWODT_ONB_5          6'h12
`define DWODT_ONB_6          6'h14
`define DWODT_ONB_7          6'h18
`define DWODT_OFFA_3         6'h14
`define DWODT_OFFA_4         6'h16
`define DWODT_OFFA_5         6'h18
`define DWODT_OFFA_6         6'h1a
`define DWODT_OFFA_7         6'h1c
`define DWODT_OFFB_2         6'h16
`define DWODT_OFFB_3         6'h1c
`define DWODT_OFFB_4         6'h20
`define DWODT_OFFB_5         6'h24
`define DWODT_OFFB_6         6'h28
`define DWODT_OFFB_7         6'h2c
`define DWODT_BL32_EXTRA     6'h08

`endif

// [include/dwodt_pkg.sv]
// Purpose: Types for the write termination controller
// Assumes: Nothing
// Notes:   Control struct order fixes the register bit positions
package dwodt_pkg;

  typedef logic [2:0] dwodt_band_type;
  typedef logic [5:0] dwodt_lat_type;

  // Bits [6:4] command bus select, [3] enable, [2:0] data resistance select
  typedef struct packed {
    logic [2:0] ca_sel;
    logic       enable;
    logic [2:0] rtt_sel;
  } dwodt_cfg_type;

  // Bits [6] low power, [5] write leveling, [4] 32-beat, [3] set B, [2:0] band
  typedef struct packed {
    logic           low_power;
    logic           write_level;
    logic           burst32;
    logic           set_b;
    dwodt_band_type band;
  } dwodt_ctrl_type;

  typedef struct packed {
    logic          valid;
    dwodt_lat_type on_lat;
    dwodt_lat_type off_lat;
  } dwodt_lat_pair_type;

  typedef enum logic {tmr_idle, tmr_run} dwodt_tmr_state_type;

endpackage : dwodt_pkg

// [src/dwodt_latency_lut.sv]
// Purpose: Band and latency set to on and off latency lookup
// Assumes: Band 0 is 10-266 MHz, each step up one band
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "dwodt_consts.svh"
module dwodt_latency_lut
(
  input  wire logic                      set_b,
  input  wire logic                      burst32,
  input  wire dwodt_pkg::dwodt_band_type band,
  output dwodt_pkg::dwodt_lat_pair_type  lat
);

  dwodt_pkg::dwodt_lat_type on_lat;
  dwodt_pkg::dwodt_lat_type off_base;
  logic                     valid;

  // Bands with no defined latency leave valid low
  always_comb
  begin
    {valid, on_lat, off_base} = {1'b0, 6'h00, 6'h00};
    if (set_b)
    begin
      case (band)
        3'h2: {valid, on_lat, off_base} = {1'b1, `DWODT_ONB_2, `DWODT_OFFB_2};
        3'h3: {valid, on_lat, off_base} = {1'b1, `DWODT_ONB_3, `DWODT_OFFB_3};
        3'h4: {valid, on_lat, off_base} = {1'b1, `DWODT_ONB_4, `DWODT_OFFB_4};
        3'h5: {valid, on_lat, off_base} = {1'b1, `DWODT_ONB_5, `DWODT_OFFB_5};
        3'h6: {valid, on_lat, off_base} = {1'b1, `DWODT_ONB_6, `DWODT_OFFB_6};
        3'h7: {valid, on_lat, off_base} = {1'b1, `DWODT_ONB_7, `DWODT_OFFB_7};
        default: {valid, on_lat, off_base} = {1'b0, 6'h00, 6'h00};
      endcase
    end
    else
    begin
      case (band)
        3'h3: {valid, on_lat, off_base} = {1'b1, `DWODT_ONA_3, `DWODT_OFFA_3};
        3'h4: {valid, on_lat, off_base} = {1'b1, `DWODT_ONA_4, `DWODT_OFFA_4};
        3'h5: {valid, on_lat, off_base} = {1'b1, `DWODT_ONA_5, `DWODT_OFFA_5};
        3'h6: {valid, on_lat, off_base} = {1'b1, `DWODT_ONA_6, `DWODT_OFFA_6};
        3'h7: {valid, on_lat, off_base} = {1'b1, `DWODT_ONA_7, `DWODT_OFFA_7};
        default: {valid, on_lat, off_base} = {1'b0, 6'h00, 6'h00};
      endcase
    end
  end

  assign lat.valid   = valid;
  assign lat.on_lat  = on_lat;
  assign lat.off_lat = burst32 ? 6'(off_base + `DWODT_BL32_EXTRA) : off_base;

endmodule : dwodt_latency_lut
`default_nettype wire

// [src/dwodt_window_timer.sv]
// Purpose: Counts one termination window from the second column command
// Assumes: off_lat above on_lat, both at least one
// Notes:   A new start restarts the count and keeps a window already open
`timescale 1ns/1ps
`default_nettype none
module dwodt_window_timer
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     start,
  input  wire dwodt_pkg::dwodt_lat_type on_lat,
  input  wire dwodt_pkg::dwodt_lat_type off_lat,
  output logic                          win_next,
  output logic                          busy
);

  dwodt_pkg::dwodt_tmr_state_type state_reg;
  dwodt_pkg::dwodt_tmr_state_type state_next;
  dwodt_pkg::dwodt_lat_type       cnt_reg;
  dwodt_pkg::dwodt_lat_type       cnt_next;
  dwodt_pkg::dwodt_lat_type       on_reg;
  dwodt_pkg::dwodt_lat_type       off_reg;
  logic                           win_reg;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    win_next   = win_reg;
    case (state_reg)
      dwodt_pkg::tmr_idle:
        win_next = 1'b0;
      dwodt_pkg::tmr_run:
      begin
        cnt_next = cnt_reg + 6'h01;
        if (cnt_reg == on_reg)
          win_next = 1'b1;
        if (cnt_reg == off_reg)
        begin
          win_next   = 1'b0;
          state_next = dwodt_pkg::tmr_idle;
        end
      end
      default:
        state_next = dwodt_pkg::tmr_idle;
    endcase
    if (start)
    begin
      state_next = dwodt_pkg::tmr_run;
      cnt_next   = 6'h01;
      win_next   = win_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg <= dwodt_pkg::tmr_idle;
      cnt_reg   <= 6'h00;
      on_reg    <= 6'h00;
      off_reg   <= 6'h00;
      win_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      on_reg    <= start ? on_lat : on_reg;
      off_reg   <= start ? off_lat : off_reg;
      win_reg   <= win_next;
    end
  end

  assign busy = (state_reg == dwodt_pkg::tmr_run);

endmodule : dwodt_window_timer
`default_nettype wire

// [src/dwodt_top.sv]
// Purpose: Data-path termination control around write bursts, AXI4-Lite regs
// Assumes: clk_sys is the device clock; command strobes are one cycle wide
// Notes:   Termination enables are registered; latencies in clock cycles
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dwodt_consts.svh"
module dwodt_top
#(
  parameter int DQ_W   = 16,
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              wr_cmd_first,
  input  wire logic              col_cmd_second,
  output logic [DQ_W-1:0]        dq_term_en,
  output logic                   dmi_term_en,
  output logic                   dqs_t_term_en,
  output logic                   dqs_c_term_en,
  output logic [2:0]             termination_resistance_sel
);

  // ****************************************
  // Declarations
  // ****************************************
  dwodt_pkg::dwodt_cfg_type      cfg_reg;
  dwodt_pkg::dwodt_cfg_type      cfg_next;
  dwodt_pkg::dwodt_ctrl_type     ctrl_reg;
  dwodt_pkg::dwodt_ctrl_type     ctrl_next;
  dwodt_pkg::dwodt_lat_pair_type lat;
  logic                          aw_full_reg;
  logic [ADDR_W-1:0]             awaddr_reg;
  logic                          w_full_reg;
  logic [31:0]                   wdata_reg;
  logic [3:0]                    wstrb_reg;
  logic                          bvalid_reg;
  logic [1:0]                    bresp_reg;
  logic                          rvalid_reg;
  logic [31:0]                   rdata_reg;
  logic [1:0]                    rresp_reg;
  logic                          aw_take;
  logic                          w_take;
  logic                          ar_take;
  logic                          wr_fire;
  logic [ADDR_W-1:0]             wr_addr;
  logic [ADDR_W-1:0]             wr_word;
  logic [ADDR_W-1:0]             rd_word;
  logic [31:0]                   wr_data;
  logic [3:0]                    wr_strb;
  logic                          wr_cfg;
  logic                          wr_ctrl;
  logic                          wr_stat;
  logic                          wr_hit;
  logic                          rd_hit;
  logic [31:0]                   rd_mux;
  logic [31:0]                   stat_word;
  logic [31:0]                   lat_word;
  logic [7:0]                    ohms;
  logic                          pending_reg;
  logic                          gate_norm;
  logic                          gate_strobe;
  logic                          start;
  logic                          win_next;
  logic                          busy;
  logic                          dq_on_reg;
  logic                          dq_on_next;
  logic                          dqs_on_reg;
  logic                          dqs_on_next;
  logic                          fault_reg;
  logic                          fault_set;
  logic                          fault_clr;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data are held separately so either may arrive first
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_fire       = (aw_full_reg || aw_take) && (w_full_reg || w_take) && !bvalid_reg;
  assign wr_addr       = aw_full_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data       = w_full_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb       = w_full_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_word       = {wr_addr[ADDR_W-1:2], 2'b00};
  assign wr_cfg        = wr_fire && (wr_word == ADDR_W'(`DWODT_CFG_OFFSET));
  assign wr_ctrl       = wr_fire && (wr_word == ADDR_W'(`DWODT_CTRL_OFFSET));
  assign wr_stat       = wr_fire && (wr_word == ADDR_W'(`DWODT_STAT_OFFSET));
  assign wr_hit        = wr_cfg || wr_ctrl || wr_stat
                         || (wr_word == ADDR_W'(`DWODT_LAT_OFFSET));

  // Only the low byte lane carries the config and control fields
  assign cfg_next  = (wr_cfg && wr_strb[0]) ? wr_data[6:0] : cfg_reg;
  assign ctrl_next = (wr_ctrl && wr_strb[0]) ? wr_data[6:0] : ctrl_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `DWODT_RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      cfg_reg     <= `DWODT_CFG_RST;
      ctrl_reg    <= `DWODT_CTRL_RST;
    end
    else
    begin
      aw_full_reg <= (aw_full_reg || aw_take) && !wr_fire;
      w_full_reg  <= (w_full_reg || w_take) && !wr_fire;
      bvalid_reg  <= wr_fire || (bvalid_reg && !s_axi_bready);
      bresp_reg   <= wr_fire ? (wr_hit ? `DWODT_RESP_OKAY : `DWODT_RESP_DECERR) : bresp_reg;
      awaddr_reg  <= aw_take ? s_axi_awaddr : awaddr_reg;
      wdata_reg   <= w_take ? s_axi_wdata : wdata_reg;
      wstrb_reg   <= w_take ? s_axi_wstrb : wstrb_reg;
      cfg_reg     <= cfg_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = !rvalid_reg;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_word       = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  assign stat_word = {15'h0000, fault_reg, ohms, 4'h0, lat.valid, busy, dqs_on_reg, dq_on_reg};
  assign lat_word  = {18'h00000, lat.off_lat, 2'b00, lat.on_lat};

  assign rd_hit = (rd_word == ADDR_W'(`DWODT_CFG_OFFSET))
                  || (rd_word == ADDR_W'(`DWODT_CTRL_OFFSET))
                  || (rd_word == ADDR_W'(`DWODT_STAT_OFFSET))
                  || (rd_word == ADDR_W'(`DWODT_LAT_OFFSET));
  assign rd_mux = (rd_word == ADDR_W'(`DWODT_CFG_OFFSET))  ? {25'h0000000, cfg_reg}  :
                  (rd_word == ADDR_W'(`DWODT_CTRL_OFFSET)) ? {25'h0000000, ctrl_reg} :
                  (rd_word == ADDR_W'(`DWODT_STAT_OFFSET)) ? stat_word :
                  (rd_word == ADDR_W'(`DWODT_LAT_OFFSET))  ? lat_word  : 32'h0000_0000;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `DWODT_RESP_OKAY;
    end
    else
    begin
      rvalid_reg <= ar_take || (rvalid_reg && !s_axi_rready);
      rdata_reg  <= ar_take ? rd_mux : rdata_reg;
      rresp_reg  <= ar_take ? (rd_hit ? `DWODT_RESP_OKAY : `DWODT_RESP_DECERR) : rresp_reg;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // ****************************************
  // Latency lookup and window timing
  // ****************************************
  dwodt_latency_lut i_dwodt_latency_lut
  (
    .set_b   (ctrl_reg.set_b),
    .burst32 (ctrl_reg.burst32),
    .band    (ctrl_reg.band),
    .lat     (lat)
  );

  // Write-first arms the window; the following column command starts the count
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      pending_reg <= 1'b0;
    else
      pending_reg <= wr_cmd_first || (pending_reg && !col_cmd_second);
  end

  assign gate_norm   = cfg_reg.enable && !ctrl_reg.low_power && !ctrl_reg.write_level;
  assign gate_strobe = cfg_reg.enable && !ctrl_reg.low_power && ctrl_reg.write_level;
  assign start       = col_cmd_second && pending_reg && gate_norm && lat.valid;

  dwodt_window_timer i_dwodt_window_timer
  (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .start    (start),
    .on_lat   (lat.on_lat),
    .off_lat  (lat.off_lat),
    .win_next (win_next),
    .busy     (busy)
  );

  // Window closes by itself after the burst; outside it pins stay high impedance, except the strobes in write leveling
  assign dq_on_next  = win_next && gate_norm;
  assign dqs_on_next = dq_on_next || gate_strobe;

  // Sticky note of a write seen in a band with no defined latency; set wins
  assign fault_set = col_cmd_second && pending_reg && gate_norm && !lat.valid;
  assign fault_clr = wr_stat && wr_strb[2] && wr_data[`DWODT_STAT_FAULT_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      dq_on_reg  <= 1'b0;
      dqs_on_reg <= 1'b0;
      fault_reg  <= 1'b0;
    end
    else
    begin
      dq_on_reg  <= dq_on_next;
      dqs_on_reg <= dqs_on_next;
      fault_reg  <= fault_set || (fault_reg && !fault_clr);
    end
  end

  // ****************************************
  // Pin enables and resistance
  // ****************************************
  assign dq_term_en    = {DQ_W{dq_on_reg}};
  assign dmi_term_en   = dq_on_reg;
  assign dqs_t_term_en = dqs_on_reg;
  assign dqs_c_term_en = dqs_on_reg;

  assign termination_resistance_sel = cfg_reg.rtt_sel;
  assign ohms = (cfg_reg.rtt_sel == 3'h1) ? 8'hf0 :
                (cfg_reg.rtt_sel == 3'h2) ? 8'h78 :
                (cfg_reg.rtt_sel == 3'h3) ? 8'h50 :
                (cfg_reg.rtt_sel == 3'h4) ? 8'h3c :
                (cfg_reg.rtt_sel == 3'h5) ? 8'h30 :
                (cfg_reg.rtt_sel == 3'h6) ? 8'h28 : 8'h00;

  // ****************************************
  // Assertions
  // ****************************************
  // Helper: cycles since the last window start and the latencies it used
  logic [6:0]               since_reg;
  dwodt_pkg::dwodt_lat_type seen_on_reg;
  dwodt_pkg::dwodt_lat_type seen_off_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      since_reg    <= 7'h7f;
      seen_on_reg  <= 6'h00;
      seen_off_reg <= 6'h00;
    end
    else
    begin
      since_reg    <= start ? 7'h01 : ((since_reg == 7'h7f) ? since_reg : since_reg + 7'h01);
      seen_on_reg  <= start ? lat.on_lat : seen_on_reg;
      seen_off_reg <= start ? lat.off_lat : seen_off_reg;
    end
  end

  default clocking dwodt_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_hiz_when_disabled: assert property (!cfg_reg.enable |=> !dq_on_reg && !dqs_on_reg)
    else $error("termination on while disabled");
  a_start_after_write: assert property ($rose(busy) |-> $past(pending_reg))
    else $error("window started without a write command");
  a_window_closes: assert property ($fell(busy) |-> !dq_on_reg)
    else $error("termination still on after window end");
  a_on_latency_count: assert property ($rose(dq_on_reg) && $past(gate_norm, 2)
      |-> since_reg == {1'b0, seen_on_reg} + 7'h01)
    else $error("termination on at wrong latency");
  a_off_latency_count: assert property ($fell(dq_on_reg) && $past(gate_norm)
      |-> since_reg == {1'b0, seen_off_reg} + 7'h01)
    else $error("termination off at wrong latency");
  a_long_burst_extra: assert property (ctrl_reg.burst32 && ctrl_reg.set_b
      && ctrl_reg.band == 3'h7 |-> lat.off_lat == 6'h34)
    else $error("long burst off latency wrong");
  a_band_no_latency: assert property ((ctrl_reg.band < 3'h2)
      || (!ctrl_reg.set_b && ctrl_reg.band < 3'h3) |-> !lat.valid && !start)
    else $error("latency given in undefined band");
  a_level_strobes_on: assert property (gate_strobe |=> dqs_t_term_en && dqs_c_term_en)
    else $error("strobe termination off in write leveling");
  a_level_data_off: assert property (ctrl_reg.write_level |=> !dq_on_reg ##1 !dq_on_reg)
    else $error("data termination on in write leveling");
  a_ohm_decode: assert property (cfg_reg.rtt_sel == 3'h3 |-> ohms == 8'h50)
    else $error("resistance decode wrong");
  a_all_pins_same: assert property (dq_term_en == {DQ_W{dmi_term_en}}
      && dqs_t_term_en == dqs_c_term_en && (dmi_term_en -> dqs_t_term_en))
    else $error("pins disagree on termination");
  a_low_power_off: assert property (ctrl_reg.low_power |=> !dq_on_reg && !dqs_on_reg)
    else $error("termination on in low power");
  a_fault_set_wins: assert property (fault_set |=> fault_reg)
    else $error("band fault not recorded");
  a_window_after_start: assert property (start |=> busy)
    else $error("window not started after command");
  a_window_bounded: assert property (since_reg > 7'h35 |-> !busy)
    else $error("window still open past longest off latency");
  a_ohm_full_decode: assert property ((cfg_reg.rtt_sel != 3'h0) && (cfg_reg.rtt_sel != 3'h7)
      |-> 11'(ohms) * 11'(cfg_reg.rtt_sel) == 11'h0f0)
    else $error("resistance decode not a fraction of reference");

  c_write_window: cover property (start ##1 busy [*3] ##[1:60] $fell(dq_on_reg));
  c_long_burst: cover property (start && ctrl_reg.burst32);
  c_level_strobe: cover property (gate_strobe ##1 dqs_on_reg);
  c_band_fault: cover property (fault_set);
  c_fault_clear: cover property (fault_reg && fault_clr && !fault_set);

endmodule : dwodt_top
`default_nettype wire

// [test/dwodt_ctrl_model.sv]
// Purpose: Memory controller model issuing write command pairs
// Assumes: Requests come one at a time, after reset
// Notes:   Gap stretches the wait between the two command halves
`timescale 1ns/1ps
`default_nettype none
module dwodt_ctrl_model
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       req,
  input  wire logic       no_first,
  input  wire logic [1:0] gap,
  output logic            wr_cmd_first,
  output logic            col_cmd_second
);
  initial
  begin
    wr_cmd_first = 1'b0;
    col_cmd_second = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      col_cmd_second <= 1'b0;
      if (req && rst_b)
      begin
        // Dropping the first half is only done when the bench asks for it
        wr_cmd_first <= !no_first;
        @(posedge clk_sys);
        wr_cmd_first <= 1'b0;
        repeat (gap) @(posedge clk_sys);
        col_cmd_second <= 1'b1;
      end
    end
  end
endmodule : dwodt_ctrl_model
`default_nettype wire

// [test/dwodt_top_bench.sv]
// Purpose: Self-checking bench for the write termination controller
// Assumes: The controller model issues the command pairs
// Notes:   Latency tables are kept here, apart from the design
`timescale 1ns/1ps
`default_nettype none
module dwodt_top_bench;
  localparam int ONA[8]  = '{0, 0, 0, 4, 4, 6, 6, 8};
  localparam int ONB[8]  = '{0, 0, 6, 12, 14, 18, 20, 24};
  localparam int OFFA[8] = '{0, 0, 0, 20, 22, 24, 26, 28};
  localparam int OFFB[8] = '{0, 0, 22, 28, 32, 36, 40, 44};
  logic        clk_sys = 1'b0, rst_b = 1'b0, awv, wv, bready, arv, rready, req, nf;
  logic        awready, wready, bvalid, arready, rvalid, wcf, ccs, data_mask_inversion_pin, dqst, dqsc;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdata, d;
  logic [1:0]  bresp, rresp, gap, r;
  logic [15:0] dq;
  logic [2:0]  rsel;
  logic [6:0]  c;
  int          fails, n_checks, on, off, eon, eoff;
  always #5 clk_sys = ~clk_sys;
  dwodt_top i_dwodt_top
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wr_cmd_first(wcf),
    .col_cmd_second(ccs), .dq_term_en(dq), .dmi_term_en(data_mask_inversion_pin), .dqs_t_term_en(dqst),
    .dqs_c_term_en(dqsc), .termination_resistance_sel(rsel)
  );
  dwodt_ctrl_model i_dwodt_ctrl_model
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .no_first(nf), .gap(gap),
    .wr_cmd_first(wcf), .col_cmd_second(ccs)
  );
  // ********************
  // Checks and bus cycles
  // ********************
  function automatic logic [31:0] ohm(input int s);
    return (s >= 1 && s <= 6) ? 32'(240 / s) : 32'h0;
  endfunction : ohm
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    awa <= a;
    wd <= v;
    {awv, wv, bready} <= 3'h7;
    for (int t = 0; t < 40; t++)
    begin
      @(posedge clk_sys);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        r = bresp;
        break;
      end
    end
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    ara <= a;
    {arv, rready} <= 2'h3;
    for (int t = 0; t < 40; t++)
    begin
      @(posedge clk_sys);
      if (arready) arv <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        {r, d} = {rresp, rdata};
        break;
      end
    end
  endtask : axr
  task automatic setup(input logic [6:0] ctl, input logic [2:0] sel, input logic en);
    axw(8'h00, 32'({3'($urandom), en, sel}));
    axw(8'h04, 32'(ctl));
  endtask : setup
  // Counts edges after the second command until termination rises and falls
  task automatic win(input logic f);
    {on, off} = '0;
    @(posedge clk_sys);
    {req, nf, gap} <= {1'b1, f, 2'($urandom)};
    @(posedge clk_sys);
    req <= 1'b0;
    for (int t = 0; t < 9 && !ccs; t++) @(posedge clk_sys);
    for (int k = 1; k < 64; k++)
    begin
      @(posedge clk_sys);
      #1;
      if (dq[0] && on == 0) on = k;
      if (!dq[0] && on != 0 && off == 0) off = k;
      if (k == on) chk(32'({dq, data_mask_inversion_pin, dqst, dqsc}), 32'h7ffff);
    end
  endtask : win
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  initial
  begin
    {awv, wv, bready, arv, rready, req, nf, awa, ara, wd, gap} = '0;
    {fails, n_checks} = '0;
    void'($urandom(37562));
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    axr(8'h04);
    chk(d, 32'h0);
    axr(8'h10);
    chk(32'(r), 32'h3);
    axw(8'h14, 32'h1);
    chk(32'(r), 32'h3);
    for (int s = 0; s < 8; s++)
    begin
      setup(7'h03, 3'(s), 1'b1);
      chk(32'(rsel), 32'(s));
      axr(8'h08);
      chk(32'(d[15:8]), ohm(s));
    end
    $display("test regs done, mismatches %0d", fails);
    for (int i = 0; i < 16; i++)
    begin
      // Corners first: slowest set A band with latency, 32-beat set B, and a band with no latency
      c = (i == 0) ? 7'h03 : (i == 1) ? 7'h1f : (i == 2) ? 7'h02 : {2'h0, 5'($urandom)};
      setup(c, 3'($urandom), 1'b1);
      win(1'b0);
      eon = c[3] ? ONB[c[2:0]] : ONA[c[2:0]];
      eoff = (c[3] ? OFFB[c[2:0]] : OFFA[c[2:0]]) + 8 * c[4];
      chk(on, eon);
      chk(off, eon == 0 ? 0 : eoff);
      axr(8'h08);
      chk(32'(d[16]), 32'(eon == 0 || i > 2));
      chk(32'(d[3]), 32'(eon != 0));
      axr(8'h0c);
      chk(32'({d[13:8], d[5:0]}), 32'({6'(eoff), 6'(eon)}));
    end
    // The sticky fault from the undefined band must clear on a write of one
    axw(8'h08, 32'h0001_0000);
    axr(8'h08);
    chk(32'(d[16]), 32'h0);
    $display("test windows done, mismatches %0d", fails);
    setup(7'h03, 3'h1, 1'b0);
    win(1'b0);
    chk(on, 0);
    setup(7'h43, 3'h1, 1'b1);
    win(1'b0);
    chk(on, 0);
    setup(7'h03, 3'h1, 1'b1);
    win(1'b1);
    chk(on, 0);
    setup(7'h23, 3'h1, 1'b1);
    win(1'b0);
    chk(32'({dqst, dqsc, data_mask_inversion_pin, dq[0], on[0]}), 32'h18);
    setup(7'h23, 3'h1, 1'b0);
    @(posedge clk_sys);
    #1;
    chk(32'({dqst, dqsc, data_mask_inversion_pin, dq[0]}), 32'h0);
    $display("test gating done, mismatches %0d", fails);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end
endmodule : dwodt_top_bench
`default_nettype wire
